//--- hw/csr_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// clock status readback constants
// ----------------------------------------------------------------------------
package csr_pkg;

  // ----------------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [11:0] OFS_FAST_START_TASK = 12'h000;
  localparam logic [11:0] OFS_SLOW_START_TASK = 12'h008;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h100;
  localparam logic [11:0] OFS_INT_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_INT_DISABLE = 12'h308;
  localparam logic [11:0] OFS_HF_START_TRIGGERED = 12'h408;
  localparam logic [11:0] OFS_HF_CLOCK_STATUS = 12'h40c;
  localparam logic [11:0] OFS_LF_START_TRIGGERED = 12'h414;
  localparam logic [11:0] OFS_LF_CLOCK_STATUS = 12'h418;
  localparam logic [11:0] OFS_LF_SOURCE_SNAPSHOT = 12'h41c;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int unsigned TASK_BIT = 0;
  localparam int unsigned TRIGGERED_BIT = 0;
  localparam int unsigned NUM_EVENTS = 2;
  // event index inside the sticky status and mask vectors
  localparam int unsigned EVT_CAL_STARTED = 0;
  localparam int unsigned EVT_CAL_STOPPED = 1;
  // position of each event inside status and enable registers
  localparam int unsigned POS_CAL_STARTED = 10;
  localparam int unsigned POS_CAL_STOPPED = 11;
  localparam int unsigned SOURCE_LSB = 0;
  localparam int unsigned SOURCE_W = 2;
  localparam int unsigned STATE_BIT = 16;

  // ----------------------------------------------------------------------------
  // source encodings and reset values
  // ----------------------------------------------------------------------------
  localparam logic [1:0] SOURCE_RC = 2'h0;
  localparam logic [1:0] SOURCE_XTAL = 2'h1;
  localparam logic [1:0] SOURCE_SYNTH = 2'h2;
  localparam logic [1:0] SOURCE_RESET = 2'h0;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] EVENTS_RESET = 2'h0;

endpackage : csr_pkg
`default_nettype wire

//--- hw/csr_irq.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// sticky event status, enable mask and level interrupt
// ----------------------------------------------------------------------------
module csr_irq (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [csr_pkg::NUM_EVENTS-1:0] evt, // event pulses
  input wire logic [csr_pkg::NUM_EVENTS-1:0] stat_clr, // write-one-to-clear bits
  input wire logic [csr_pkg::NUM_EVENTS-1:0] en_set, // enable set bits
  input wire logic [csr_pkg::NUM_EVENTS-1:0] en_clr, // enable clear bits
  output logic [csr_pkg::NUM_EVENTS-1:0] stat_r, // sticky event status
  output logic [csr_pkg::NUM_EVENTS-1:0] en_r, // interrupt enables
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------------------
  // per-event flops
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < csr_pkg::NUM_EVENTS; gi = gi + 1) begin : g_evt
      // a new event beats a clear in the same cycle so nothing is lost
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          stat_r[gi] <= 1'b0;
        end else if (ce) begin
          if (evt[gi]) begin
            stat_r[gi] <= 1'b1;
          end else if (stat_clr[gi]) begin
            stat_r[gi] <= 1'b0;
          end
        end
      end

      // disable has priority over set: software asked to silence it
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          en_r[gi] <= 1'b0;
        end else if (ce) begin
          if (en_clr[gi]) begin
            en_r[gi] <= 1'b0; // [R1] [R2]
          end else if (en_set[gi]) begin
            en_r[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // interrupt stays high while any enabled status bit is set
  assign irq = |(stat_r & en_r);

endmodule : csr_irq
`default_nettype wire

//--- hw/csr_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Overview of operation
// R1: write one disables cal-started interrupt; read enable
// R2: write one disables cal-stopped interrupt; read enable
// R3: fast start task sets its triggered status
// R4: slow start task sets its triggered status
// R5: slow status shows two-bit source field
// R6: slow start task snapshots source config
// R7: snapshot uses same encoding, resets zero
// R8: software owns source config; snapshot copies it
// R9: slow status state bit shows running clock
// ----------------------------------------------------------------------------
module csr_top (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  // register port
  input wire logic [csr_pkg::ADDR_W-1:0] addr, // byte address
  input wire logic [csr_pkg::DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [csr_pkg::DATA_W-1:0] rdata, // read data, cycle after rd
  // clock tree status
  input wire logic [1:0] slow_source_config, // configured slow source
  input wire logic [1:0] slow_source_active, // source the slow clock runs on
  input wire logic slow_clock_running, // slow clock running
  input wire logic fast_clock_running, // fast clock running
  input wire logic fast_source_xtal, // fast clock taken from crystal
  // calibration timer events
  input wire logic cal_timer_started_event, // pulse
  input wire logic cal_timer_stopped_event, // pulse
  // task pulses out to the oscillator logic
  output logic fast_clock_start_task, // one-cycle pulse
  output logic slow_clock_start_task, // one-cycle pulse
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  logic wr_ok;
  logic rd_ok;
  logic hit_fast_task;
  logic hit_slow_task;
  logic hit_evt_stat;
  logic hit_en_set;
  logic hit_en_clr;

  // the clock enable gates every strobe so a frozen block ignores the bus
  assign wr_ok = wr & ce;
  assign rd_ok = rd & ce;

  assign hit_fast_task = wr_ok && (addr == csr_pkg::OFS_FAST_START_TASK);
  assign hit_slow_task = wr_ok && (addr == csr_pkg::OFS_SLOW_START_TASK);
  assign hit_evt_stat = wr_ok && (addr == csr_pkg::OFS_EVENT_STATUS);
  assign hit_en_set = wr_ok && (addr == csr_pkg::OFS_INT_ENABLE_SET);
  assign hit_en_clr = wr_ok && (addr == csr_pkg::OFS_INT_DISABLE);

  // ----------------------------------------------------------------------------
  // task triggers
  // ----------------------------------------------------------------------------
  logic fast_task_fire;
  logic slow_task_fire;

  // only a one in the task bit fires; writing zero is a no-op
  assign fast_task_fire = hit_fast_task & wdata[csr_pkg::TASK_BIT];
  assign slow_task_fire = hit_slow_task & wdata[csr_pkg::TASK_BIT];

  logic fast_task_r;
  logic slow_task_r;

  // task pulses are registered so the oscillator side sees clean strobes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fast_task_r <= 1'b0;
      slow_task_r <= 1'b0;
    end else if (ce) begin
      fast_task_r <= fast_task_fire;
      slow_task_r <= slow_task_fire;
    end
  end

  // a frozen clock enable must not stretch the pulse
  assign fast_clock_start_task = fast_task_r & ce;
  assign slow_clock_start_task = slow_task_r & ce;

  // ----------------------------------------------------------------------------
  // triggered flags
  // ----------------------------------------------------------------------------
  logic hf_triggered_r;
  logic lf_triggered_r;

  // sticky until reset; no stop task lives in this block
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hf_triggered_r <= 1'b0;
    end else if (ce && fast_task_fire) begin
      hf_triggered_r <= 1'b1; // [R3]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lf_triggered_r <= 1'b0;
    end else if (ce && slow_task_fire) begin
      lf_triggered_r <= 1'b1; // [R4]
    end
  end

  // ----------------------------------------------------------------------------
  // source snapshot
  // ----------------------------------------------------------------------------
  logic [1:0] snapshot_r;

  // config is captured on the same edge the task is accepted, so a config
  // write in a later cycle cannot leak into the copy
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      snapshot_r <= csr_pkg::SOURCE_RESET; // [R7]
    end else if (ce && slow_task_fire) begin
      snapshot_r <= slow_source_config; // [R6] [R8]
    end
  end

  // ----------------------------------------------------------------------------
  // live status sampling
  // ----------------------------------------------------------------------------
  logic [1:0] lf_source_r;
  logic lf_running_r;
  logic hf_running_r;
  logic hf_xtal_r;

  // one stage of registering keeps the read path short from the clock tree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lf_source_r <= csr_pkg::SOURCE_RESET;
      lf_running_r <= 1'b0;
      hf_running_r <= 1'b0;
      hf_xtal_r <= 1'b0;
    end else if (ce) begin
      lf_source_r <= slow_source_active; // [R5]
      lf_running_r <= slow_clock_running; // [R9]
      hf_running_r <= fast_clock_running;
      hf_xtal_r <= fast_source_xtal;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------------
  logic [csr_pkg::NUM_EVENTS-1:0] evt_vec;
  logic [csr_pkg::NUM_EVENTS-1:0] stat_clr_vec;
  logic [csr_pkg::NUM_EVENTS-1:0] en_set_vec;
  logic [csr_pkg::NUM_EVENTS-1:0] en_clr_vec;
  logic [csr_pkg::NUM_EVENTS-1:0] evt_stat;
  logic [csr_pkg::NUM_EVENTS-1:0] evt_en;

  assign evt_vec[csr_pkg::EVT_CAL_STARTED] = cal_timer_started_event;
  assign evt_vec[csr_pkg::EVT_CAL_STOPPED] = cal_timer_stopped_event;

  // map register bit positions onto the event vector
  assign stat_clr_vec[csr_pkg::EVT_CAL_STARTED] = hit_evt_stat & wdata[csr_pkg::POS_CAL_STARTED];
  assign stat_clr_vec[csr_pkg::EVT_CAL_STOPPED] = hit_evt_stat & wdata[csr_pkg::POS_CAL_STOPPED];
  assign en_set_vec[csr_pkg::EVT_CAL_STARTED] = hit_en_set & wdata[csr_pkg::POS_CAL_STARTED];
  assign en_set_vec[csr_pkg::EVT_CAL_STOPPED] = hit_en_set & wdata[csr_pkg::POS_CAL_STOPPED];
  // zeros in the disable word leave the enables alone
  assign en_clr_vec[csr_pkg::EVT_CAL_STARTED] = hit_en_clr & wdata[csr_pkg::POS_CAL_STARTED]; // [R1]
  assign en_clr_vec[csr_pkg::EVT_CAL_STOPPED] = hit_en_clr & wdata[csr_pkg::POS_CAL_STOPPED]; // [R2]

  csr_irq u_irq (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .evt(evt_vec),
    .stat_clr(stat_clr_vec),
    .en_set(en_set_vec),
    .en_clr(en_clr_vec),
    .stat_r(evt_stat),
    .en_r(evt_en),
    .irq(irq)
  );

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  logic [csr_pkg::DATA_W-1:0] rd_nxt;
  logic [csr_pkg::DATA_W-1:0] rdata_r;

  // unmapped and write-only addresses read as zero
  always_comb begin
    rd_nxt = csr_pkg::REG_RESET;
    case (addr)
      csr_pkg::OFS_EVENT_STATUS: begin
        rd_nxt[csr_pkg::POS_CAL_STARTED] = evt_stat[csr_pkg::EVT_CAL_STARTED];
        rd_nxt[csr_pkg::POS_CAL_STOPPED] = evt_stat[csr_pkg::EVT_CAL_STOPPED];
      end
      csr_pkg::OFS_INT_ENABLE_SET, csr_pkg::OFS_INT_DISABLE: begin
        // both views read back one for enabled, zero for disabled
        rd_nxt[csr_pkg::POS_CAL_STARTED] = evt_en[csr_pkg::EVT_CAL_STARTED]; // [R1]
        rd_nxt[csr_pkg::POS_CAL_STOPPED] = evt_en[csr_pkg::EVT_CAL_STOPPED]; // [R2]
      end
      csr_pkg::OFS_HF_START_TRIGGERED: begin
        rd_nxt[csr_pkg::TRIGGERED_BIT] = hf_triggered_r; // [R3]
      end
      csr_pkg::OFS_HF_CLOCK_STATUS: begin
        rd_nxt[csr_pkg::SOURCE_LSB] = hf_xtal_r;
        rd_nxt[csr_pkg::STATE_BIT] = hf_running_r;
      end
      csr_pkg::OFS_LF_START_TRIGGERED: begin
        rd_nxt[csr_pkg::TRIGGERED_BIT] = lf_triggered_r; // [R4]
      end
      csr_pkg::OFS_LF_CLOCK_STATUS: begin
        rd_nxt[csr_pkg::SOURCE_LSB +: csr_pkg::SOURCE_W] = lf_source_r; // [R5]
        rd_nxt[csr_pkg::STATE_BIT] = lf_running_r; // [R9]
      end
      csr_pkg::OFS_LF_SOURCE_SNAPSHOT: begin
        rd_nxt[csr_pkg::SOURCE_LSB +: csr_pkg::SOURCE_W] = snapshot_r; // [R7]
      end
      default: begin
        rd_nxt = csr_pkg::REG_RESET;
      end
    endcase
  end

  // data stands in the cycle after the strobe, zero otherwise; a low clock enable holds the last value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= csr_pkg::REG_RESET;
    end else if (ce) begin
      rdata_r <= rd_ok ? rd_nxt : csr_pkg::REG_RESET;
    end
  end

  assign rdata = rdata_r;

endmodule : csr_top
`default_nettype wire

//--- verification/csr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// register port and task checker
// ----------------------------------------------------------------------------
module csr_monitor (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [csr_pkg::ADDR_W-1:0] addr, // byte address
  input wire logic [csr_pkg::DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [csr_pkg::DATA_W-1:0] rdata, // read data
  input wire logic [1:0] slow_source_config, // configured slow source
  input wire logic [1:0] slow_source_active, // running slow source
  input wire logic slow_clock_running, // slow clock running
  input wire logic fast_clock_start_task, // task pulse
  input wire logic slow_clock_start_task // task pulse
);
  logic hf_seen_r;
  logic lf_seen_r;
  logic [1:0] snap_r;
  logic slow_wr;
  logic fast_wr;

  // start strobes as software issues them
  assign slow_wr = ce && wr && addr == csr_pkg::OFS_SLOW_START_TASK && wdata[0];
  assign fast_wr = ce && wr && addr == csr_pkg::OFS_FAST_START_TASK && wdata[0];

  // shadow of fired tasks, taken from the pulses so a dead pulse also shows
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hf_seen_r <= 1'b0;
      lf_seen_r <= 1'b0;
    end else begin
      if (fast_clock_start_task) hf_seen_r <= 1'b1;
      if (slow_clock_start_task) lf_seen_r <= 1'b1;
    end
  end

  // source shadow sampled at the start strobe edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) snap_r <= 2'h0;
    else if (slow_wr) snap_r <= slow_source_config;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // disable write followed at once by a read of the enables
  sequence s_dis_then_rd(b);
    ce && wr && addr == csr_pkg::OFS_INT_DISABLE && wdata[b] ##1 ce && rd && addr == csr_pkg::OFS_INT_DISABLE;
  endsequence

  a_fast_task_pulse: assert property (fast_wr |=> fast_clock_start_task)
    else $error("fast start pulse missing");
  a_slow_task_pulse: assert property (slow_wr |=> slow_clock_start_task)
    else $error("slow start pulse missing");
  a_hf_trig_read: assert property (ce && rd && addr == csr_pkg::OFS_HF_START_TRIGGERED |=> rdata == {31'h0, hf_seen_r})
    else $error("fast triggered status wrong");
  a_lf_trig_read: assert property (ce && rd && addr == csr_pkg::OFS_LF_START_TRIGGERED |=> rdata == {31'h0, lf_seen_r})
    else $error("slow triggered status wrong");
  a_snapshot_read: assert property (ce && rd && addr == csr_pkg::OFS_LF_SOURCE_SNAPSHOT |=> rdata == {30'h0, snap_r})
    else $error("source snapshot wrong");
  a_lf_status_read: assert property ($past(nrst) && ce && rd && addr == csr_pkg::OFS_LF_CLOCK_STATUS
    && $stable(slow_source_active) && $stable(slow_clock_running)
    |=> rdata == {15'h0, $past(slow_clock_running), 14'h0, $past(slow_source_active)})
    else $error("slow status wrong");
  a_dis_started: assert property (s_dis_then_rd(csr_pkg::POS_CAL_STARTED) |=> !rdata[csr_pkg::POS_CAL_STARTED])
    else $error("started interrupt still enabled");
  a_dis_stopped: assert property (s_dis_then_rd(csr_pkg::POS_CAL_STOPPED) |=> !rdata[csr_pkg::POS_CAL_STOPPED])
    else $error("stopped interrupt still enabled");
  a_rdata_idle_zero: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("read data outside read slot");
endmodule : csr_monitor

bind csr_top csr_monitor u_mon (.mclk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata, .slow_source_config,
  .slow_source_active, .slow_clock_running, .fast_clock_start_task, .slow_clock_start_task);
`default_nettype wire

//--- verification/tb_clock_status_readback.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clock_status_readback;
  logic mclk, nrst, ce, wr, rd, irq;
  logic [csr_pkg::ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] slow_source_config, slow_source_active;
  logic slow_clock_running, fast_clock_running, fast_source_xtal;
  logic cal_timer_started_event, cal_timer_stopped_event, fast_clock_start_task, slow_clock_start_task;
  logic [1:0] srcs [3] = '{csr_pkg::SOURCE_RC, csr_pkg::SOURCE_XTAL, csr_pkg::SOURCE_SYNTH};
  int fails, comparisons;

  csr_top dut_u (.mclk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata, .slow_source_config, .slow_source_active,
    .slow_clock_running, .fast_clock_running, .fast_source_xtal, .cal_timer_started_event,
    .cal_timer_stopped_event, .fast_clock_start_task, .slow_clock_start_task, .irq);

  // 40 mhz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task end_sim;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask : rd_chk

  // write then read back on the very next cycle, no idle slot between
  task wr_rd(input string name, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask : wr_rd

  task pulse_evt(input logic stopped);
    @(posedge mclk);
    cal_timer_started_event <= !stopped; cal_timer_stopped_event <= stopped;
    @(posedge mclk);
    cal_timer_started_event <= 1'b0; cal_timer_stopped_event <= 1'b0;
  endtask : pulse_evt

  // bounded wait; a stuck level ends the run
  task wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("irq", {31'h0, irq}, {31'h0, exp});
    if (irq !== exp) end_sim();
  endtask : wait_irq

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task t_reset_values;
    rd_chk("hf_start_triggered", csr_pkg::OFS_HF_START_TRIGGERED, 32'h0);
    rd_chk("lf_start_triggered", csr_pkg::OFS_LF_START_TRIGGERED, 32'h0);
    rd_chk("lf_source_snapshot", csr_pkg::OFS_LF_SOURCE_SNAPSHOT, 32'h0);
    rd_chk("unmapped", 12'h7fc, 32'h0);
    wait_irq(1'b0);
  endtask : t_reset_values

  task t_irq_disable;
    bus_wr(csr_pkg::OFS_INT_ENABLE_SET, 32'h0000_0c00);
    rd_chk("interrupt_disable", csr_pkg::OFS_INT_DISABLE, 32'h0000_0c00);
    pulse_evt(1'b0);
    wait_irq(1'b1);
    rd_chk("event_status", csr_pkg::OFS_EVENT_STATUS, 32'h0000_0400);
    bus_wr(csr_pkg::OFS_INT_DISABLE, 32'h0); // zero writes leave enables alone
    rd_chk("interrupt_enable", csr_pkg::OFS_INT_ENABLE_SET, 32'h0000_0c00);
    wr_rd("interrupt_disable", csr_pkg::OFS_INT_DISABLE, 32'h0000_0400, 32'h0000_0800);
    wait_irq(1'b0);
    bus_wr(csr_pkg::OFS_EVENT_STATUS, 32'h0000_0400);
    pulse_evt(1'b1);
    wait_irq(1'b1);
    wr_rd("interrupt_disable", csr_pkg::OFS_INT_DISABLE, 32'h0000_0800, 32'h0);
    rd_chk("interrupt_enable", csr_pkg::OFS_INT_ENABLE_SET, 32'h0);
    wait_irq(1'b0);
    bus_wr(csr_pkg::OFS_EVENT_STATUS, 32'h0000_0c00);
  endtask : t_irq_disable

  // every source code with the clock both stopped and running
  task t_lf_status;
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge mclk);
        slow_source_active <= srcs[i]; slow_clock_running <= j[0];
        repeat (2) @(posedge mclk);
        rd_chk("lf_clock_status", csr_pkg::OFS_LF_CLOCK_STATUS, {15'h0, j[0], 14'h0, srcs[i]});
      end
    end
    // fast clock status: crystal source in bit 0, running in bit 16
    @(posedge mclk);
    fast_clock_running <= 1'b1; fast_source_xtal <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_chk("hf_clock_status", csr_pkg::OFS_HF_CLOCK_STATUS, 32'h0001_0001);
  endtask : t_lf_status

  task t_start_tasks;
    @(posedge mclk);
    slow_source_config <= csr_pkg::SOURCE_SYNTH;
    bus_wr(csr_pkg::OFS_LF_SOURCE_SNAPSHOT, 32'h0000_0001); // read-only, must be ignored
    rd_chk("lf_source_snapshot", csr_pkg::OFS_LF_SOURCE_SNAPSHOT, 32'h0);
    bus_wr(csr_pkg::OFS_SLOW_START_TASK, 32'h1);
    check("slow_clock_start_task", {31'h0, slow_clock_start_task}, 32'h1);
    rd_chk("lf_start_triggered", csr_pkg::OFS_LF_START_TRIGGERED, 32'h1);
    @(posedge mclk);
    slow_source_config <= csr_pkg::SOURCE_XTAL;
    rd_chk("lf_source_snapshot", csr_pkg::OFS_LF_SOURCE_SNAPSHOT, {30'h0, csr_pkg::SOURCE_SYNTH});
    bus_wr(csr_pkg::OFS_SLOW_START_TASK, 32'h1);
    rd_chk("lf_source_snapshot", csr_pkg::OFS_LF_SOURCE_SNAPSHOT, {30'h0, csr_pkg::SOURCE_XTAL});
    rd_chk("hf_start_triggered", csr_pkg::OFS_HF_START_TRIGGERED, 32'h0);
    bus_wr(csr_pkg::OFS_FAST_START_TASK, 32'h1);
    check("fast_clock_start_task", {31'h0, fast_clock_start_task}, 32'h1);
    rd_chk("hf_start_triggered", csr_pkg::OFS_HF_START_TRIGGERED, 32'h1);
  endtask : t_start_tasks

  // a low clock enable must swallow bus strobes and hold all state
  task t_freeze;
    @(posedge mclk);
    ce <= 1'b0;
    bus_wr(csr_pkg::OFS_INT_ENABLE_SET, 32'h0000_0c00);
    bus_wr(csr_pkg::OFS_SLOW_START_TASK, 32'h1);
    check("slow_clock_start_task", {31'h0, slow_clock_start_task}, 32'h0);
    @(posedge mclk);
    ce <= 1'b1;
    rd_chk("interrupt_enable", csr_pkg::OFS_INT_ENABLE_SET, 32'h0);
  endtask : t_freeze

  // main sequence; clock enable drops only in the freeze scenario
  initial begin
    fails = 0; comparisons = 0;
    nrst = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
    slow_source_config = 2'h0; slow_source_active = 2'h0; slow_clock_running = 1'b0;
    fast_clock_running = 1'b0; fast_source_xtal = 1'b0;
    cal_timer_started_event = 1'b0; cal_timer_stopped_event = 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_reset_values();
    t_irq_disable();
    t_lf_status();
    t_start_tasks();
    t_freeze();
    end_sim();
  end
endmodule : tb_clock_status_readback
`default_nettype wire
